/* File: core/rwi_pkg.sv */
// Shared constants for the clock-side watchdog and interrupt logic
package rwi_pkg;
    // ==========================================================
    // Clock and timing
    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned WDT_DIV      = 1024;
    localparam int unsigned PULSE_MS     = 200;
    localparam int unsigned PULSE_CYCLES = PULSE_MS * (CLK_HZ / 1000);

    // ==========================================================
    // Register indices, byte address is four times the index
    localparam logic [5:0] IDX_FLAGS = 6'h00;
    localparam logic [5:0] IDX_INTR  = 6'h06;
    localparam logic [5:0] IDX_WDOG  = 6'h07;

    // ==========================================================
    // Flags register fields
    localparam int unsigned FLG_WDF  = 7;
    localparam int unsigned FLG_AF   = 6;
    localparam int unsigned FLG_PF   = 5;
    localparam int unsigned FLG_OSCILLATOR_FAIL_FLAG = 4;
    localparam int unsigned FLG_CAL  = 2;
    localparam int unsigned FLG_W    = 1;
    localparam int unsigned FLG_R    = 0;

    // ==========================================================
    // Interrupt control fields and reset values
    localparam int unsigned INT_WIE = 7;
    localparam int unsigned INT_AIE = 6;
    localparam int unsigned INT_PFE = 5;
    localparam int unsigned INT_HL  = 3;
    localparam int unsigned INT_PL  = 2;
    localparam logic        HL_RESET = 1'b1;
    localparam logic        PL_RESET = 1'b0;

    // ==========================================================
    // Watchdog control fields and reset values
    localparam int unsigned WD_STROBE = 7;
    localparam int unsigned WD_LOCK   = 6;
    localparam int unsigned WD_VAL_W  = 6;
    localparam logic [5:0]  WDT_RESET = 6'h00;

    // ==========================================================
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

/* File: core/rwi_tick_div.sv */
// Divides a stream of single-cycle input ticks into a slower tick
`timescale 1ns/1ps
`default_nettype none
module rwi_tick_div #(
    parameter int unsigned DIV = 1024
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Ticks
    input  wire logic in_tick,
    input  wire logic en,
    output logic      out_tick
);
    localparam int unsigned CW = $clog2(DIV);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } rwi_div_t;

    rwi_div_t s;
    rwi_div_t next_s;

    always_comb begin
        next_s      = s;
        next_s.tick = 1'b0;
        // Holds still while the oscillator is stopped
        if (en && in_tick) begin
            if (s.cnt == CW'(DIV - 1)) begin
                next_s.cnt  = '0;
                next_s.tick = 1'b1;
            end else begin
                next_s.cnt = s.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign out_tick = s.tick;
endmodule
`default_nettype wire

/* File: core/rwi_pulse_timer.sv */
// Fixed-length pulse timer that can be cut short
`timescale 1ns/1ps
`default_nettype none
module rwi_pulse_timer #(
    parameter int unsigned CYCLES = 25_000_000
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Control
    input  wire logic start,
    input  wire logic abort,
    output logic      busy
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          busy;
    } rwi_pt_t;

    rwi_pt_t s;
    rwi_pt_t next_s;

    always_comb begin
        next_s = s;
        // Abort wins so a flags read off backup power always ends the pulse
        if (abort) begin
            next_s = '0;
        end else if (start && !s.busy) begin
            next_s.busy = 1'b1;
            next_s.cnt  = CW'(CYCLES - 1);
        end else if (s.busy) begin
            if (s.cnt == '0) begin
                next_s.busy = 1'b0;
            end else begin
                next_s.cnt = s.cnt - CW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy = s.busy;
endmodule
`default_nettype wire

/* File: core/rwi_rtc_irq.sv */
// Watchdog, event flags and interrupt pin logic behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module rwi_rtc_irq #(
    parameter int unsigned PULSE_CYCLES = rwi_pkg::PULSE_CYCLES,
    parameter int unsigned WDT_DIV      = rwi_pkg::WDT_DIV
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Oscillator and event sources
    input  wire logic        osc_tick,
    input  wire logic        osc_running,
    input  wire logic        alarm_match,
    input  wire logic        power_fail,
    input  wire logic        osc_fail,
    input  wire logic        on_backup,
    // Interrupt pin
    output logic             int_o,
    output logic             int_oe
);
    // ==========================================================
    // State
    typedef struct packed {
        logic        watchdog_timeout_flag;
        logic        af;
        logic        pf;
        logic        oscillator_fail_flag;
        logic        cal;
        logic        wen;
        logic        rdl;
        logic        watchdog_irq_enable;
        logic        alarm_irq_enable;
        logic        powerfail_irq_enable;
        logic        hl;
        logic        pl;
        logic        timeout_write_lock_bit;
        logic [5:0]  wdt;
        logic [5:0]  cnt;
        logic        load_pend;
        logic        aw_held;
        logic [5:0]  aw_idx;
        logic        w_held;
        logic [31:0] wdata;
        logic        wlane0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        prev_cond;
        logic        int_out;
        logic        int_en;
        logic        pin_hl;
    } rwi_state_t;

    localparam rwi_state_t RESET_STATE = '{
        hl: rwi_pkg::HL_RESET, pl: rwi_pkg::PL_RESET, wdt: rwi_pkg::WDT_RESET,
        load_pend: 1'b1, int_en: rwi_pkg::HL_RESET, pin_hl: rwi_pkg::HL_RESET, default: '0};

    rwi_state_t s;
    rwi_state_t next_s;

    logic       wdt_tick;
    logic       pulse_busy;
    logic       pulse_start;
    logic       flags_clr;
    logic       timeout;
    logic       strobe;
    logic       wr_commit;
    logic       wr_ok;
    logic       cond;
    logic       active;
    logic [5:0] new_wdt;
    logic [5:0] ar_idx;

    // ==========================================================
    // Tick and pulse helpers
    // divide oscillator ticks
    rwi_tick_div #(
        .DIV      (WDT_DIV)
    ) u_tick (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .in_tick  (osc_tick),
        .en       (osc_running),
        .out_tick (wdt_tick)
    );

    rwi_pulse_timer #(
        .CYCLES  (PULSE_CYCLES)
    ) u_pulse (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .start   (pulse_start),
        .abort   (flags_clr),
        .busy    (pulse_busy)
    );

    // ==========================================================
    // Bus handshakes
    assign s_axi_awready = !s.aw_held && !s.bvalid;
    assign s_axi_wready  = !s.w_held && !s.bvalid;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rresp   = s.rresp;
    assign s_axi_rdata   = s.rdata;
    assign int_o         = s.int_out;
    assign int_oe        = s.int_en;
    assign ar_idx        = s_axi_araddr[7:2];

    assign wr_commit = s.aw_held && s.w_held && !s.bvalid;
    assign wr_ok     = wr_commit && !on_backup && s.wlane0;
    assign flags_clr = s_axi_arvalid && !s.rvalid && !on_backup
                       && ar_idx == rwi_pkg::IDX_FLAGS;
    // strobe bit on a watchdog write
    assign strobe    = wr_ok && s.aw_idx == rwi_pkg::IDX_WDOG
                       && s.wdata[rwi_pkg::WD_STROBE];
    assign new_wdt   = (wr_ok && s.aw_idx == rwi_pkg::IDX_WDOG
                       && !s.wdata[rwi_pkg::WD_LOCK]) ? s.wdata[5:0] : s.wdt;
    assign timeout   = !s.load_pend && !strobe && wdt_tick
                       && s.wdt != 6'h00 && s.cnt == 6'h01;

    // flag and enable, watchdog, alarm and power fail
    assign cond = ((s.watchdog_timeout_flag && s.watchdog_irq_enable) || (s.af && s.alarm_irq_enable) || (s.pf && s.powerfail_irq_enable)) && !on_backup;
    // pulse starts on a new interrupt
    assign pulse_start = cond && !s.prev_cond && s.pl;
    assign active      = (s.pl ? pulse_busy : cond) && !on_backup;

    // ==========================================================
    // Next state
    always_comb begin
        next_s           = s;
        next_s.prev_cond = cond;

        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_idx  = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata  = s_axi_wdata;
            next_s.wlane0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (wr_commit) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            if (on_backup) begin
                next_s.bresp = rwi_pkg::RESP_SLVERR;
            end else if (s.aw_idx == rwi_pkg::IDX_FLAGS || s.aw_idx == rwi_pkg::IDX_INTR
                         || s.aw_idx == rwi_pkg::IDX_WDOG) begin
                next_s.bresp = rwi_pkg::RESP_OKAY;
            end else begin
                next_s.bresp = rwi_pkg::RESP_DECERR;
            end
        end
        if (wr_ok) begin
            case (s.aw_idx)
                rwi_pkg::IDX_FLAGS: begin
                    next_s.cal = s.wdata[rwi_pkg::FLG_CAL];
                    next_s.wen = s.wdata[rwi_pkg::FLG_W];
                    next_s.rdl = s.wdata[rwi_pkg::FLG_R];
                    if (s.wen && !s.wdata[rwi_pkg::FLG_OSCILLATOR_FAIL_FLAG]) begin
                        next_s.oscillator_fail_flag = 1'b0;
                    end
                end
                rwi_pkg::IDX_INTR: begin
                    next_s.watchdog_irq_enable = s.wdata[rwi_pkg::INT_WIE];
                    next_s.alarm_irq_enable = s.wdata[rwi_pkg::INT_AIE];
                    next_s.powerfail_irq_enable = s.wdata[rwi_pkg::INT_PFE];
                    next_s.hl  = s.wdata[rwi_pkg::INT_HL];
                    next_s.pl  = s.wdata[rwi_pkg::INT_PL];
                end
                rwi_pkg::IDX_WDOG: begin
                    next_s.timeout_write_lock_bit = s.wdata[rwi_pkg::WD_LOCK];
                    next_s.wdt = new_wdt;
                end
                default: begin
                    next_s.timeout_write_lock_bit = s.timeout_write_lock_bit;
                end
            endcase
        end

        // Reads: flags value is captured before the clear lands
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = rwi_pkg::RESP_OKAY;
            next_s.rdata  = 32'h0000_0000;
            if (on_backup) begin
                next_s.rresp = rwi_pkg::RESP_SLVERR;
            end else begin
                case (ar_idx)
                    rwi_pkg::IDX_FLAGS: begin
                        next_s.rdata[7:0] = {s.watchdog_timeout_flag, s.af, s.pf, s.oscillator_fail_flag,
                                             1'b0, s.cal, s.wen, s.rdl};
                    end
                    rwi_pkg::IDX_INTR: begin
                        next_s.rdata[7:0] = {s.watchdog_irq_enable, s.alarm_irq_enable, s.powerfail_irq_enable, 1'b0,
                                             s.hl, s.pl, 2'b00};
                    end
                    rwi_pkg::IDX_WDOG: begin
                        next_s.rdata[7:0] = {1'b0, s.timeout_write_lock_bit, s.wdt};
                    end
                    default: begin
                        next_s.rresp = rwi_pkg::RESP_DECERR;
                    end
                endcase
            end
        end

        // Watchdog counter
        if (s.load_pend) begin
            next_s.cnt       = s.wdt;
            next_s.load_pend = 1'b0;
        end else if (strobe) begin
            next_s.cnt = new_wdt;
        end else if (wdt_tick && s.wdt != 6'h00) begin
            // one step per tick, tick stops with oscillator
            if (s.cnt <= 6'h01) begin
                next_s.cnt = s.wdt;
            end else begin
                next_s.cnt = s.cnt - 6'h01;
            end
        end

        // read clears all but the oscillator fail flag, set wins over the clear
        next_s.watchdog_timeout_flag  = (s.watchdog_timeout_flag && !flags_clr) || timeout;
        next_s.af   = (s.af && !flags_clr) || alarm_match;
        next_s.pf   = (s.pf && !flags_clr) || power_fail;
        next_s.oscillator_fail_flag = next_s.oscillator_fail_flag || osc_fail;

        next_s.int_out = s.hl ? active : 1'b0;
        next_s.int_en  = s.hl ? 1'b1 : active;
        // Mode the pin registers were built for, lags a mode write
        next_s.pin_hl  = s.hl;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Checks
    logic pin_act;
    assign pin_act = s.pin_hl ? s.int_out : s.int_en;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    wdt_timeout_flag_a: assert property (timeout |=> s.watchdog_timeout_flag)
        else $error("watchdog timeout did not set its flag");

    strobe_reload_a: assert property (
        (strobe && !s.load_pend) |=> s.cnt == $past(new_wdt) && (!s.watchdog_timeout_flag || $past(s.watchdog_timeout_flag)))
        else $error("strobe did not reload the counter");

    wdt_disabled_a: assert property ((s.wdt == 6'h00 && !s.watchdog_timeout_flag) |=> !s.watchdog_timeout_flag)
        else $error("disabled watchdog raised its flag");

    lock_ignore_a: assert property (
        (wr_ok && s.aw_idx == rwi_pkg::IDX_WDOG && s.wdata[rwi_pkg::WD_LOCK])
        |=> s.wdt == $past(s.wdt))
        else $error("locked timeout field was changed");

    flag_read_clear_a: assert property (
        (flags_clr && !alarm_match && !power_fail && !timeout)
        |=> !s.watchdog_timeout_flag && !s.af && !s.pf)
        else $error("flags not cleared by a read");

    backup_quiet_a: assert property (on_backup |=> !pin_act)
        else $error("interrupt pin active on backup power");

    enable_gate_a: assert property (
        (!s.pl && !s.watchdog_irq_enable && !s.alarm_irq_enable && !s.powerfail_irq_enable) |=> !pin_act)
        else $error("interrupt without an enabled source");

    level_hold_a: assert property (
        (!s.pl && cond) |=> pin_act)
        else $error("level interrupt not driven");

    drive_mode_a: assert property (s.pin_hl |-> s.int_en)
        else $error("push-pull mode lost its drive");

    open_drain_a: assert property (!s.pin_hl |-> !s.int_out)
        else $error("open-drain pin driven high");

    pulse_abort_a: assert property ((s.pl && flags_clr) |=> ##1 !pin_act)
        else $error("flags read did not end the pulse");
endmodule
`default_nettype wire

/* File: tb/rwi_host_model.sv */
// Host side of the interrupt pin: pull-up, pin level and power-up ignore window
`timescale 1ns/1ps
`default_nettype none
module rwi_host_model #(
    parameter int unsigned IGNORE_CYCLES = 16
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Pin as driven by the device
    input  wire logic int_o,
    input  wire logic int_oe,
    // Active level the host configured
    input  wire logic active_high,
    // Host view
    output logic      pin,
    output logic      irq_seen
);
    int unsigned age;

    // ==========================================================
    // Pin level
    // pull-up when not driven
    assign pin = int_oe ? int_o : 1'b1;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            age <= 0;
        end else if (age < IGNORE_CYCLES) begin
            age <= age + 1;
        end
    end

    // only a settled active level counts as a request
    assign irq_seen = (age >= IGNORE_CYCLES) && (pin === active_high);
endmodule
`default_nettype wire

/* File: tb/tb_rtc_watchdog_interrupt_logic.sv */
// Self-checking bench for the watchdog, flags and interrupt pin block
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_watchdog_interrupt_logic;
    localparam int unsigned PULSE = 20;
    localparam logic [7:0]  A_FLG = 8'h00;
    localparam logic [7:0]  A_INT = 8'h18;
    localparam logic [7:0]  A_WDG = 8'h1C;

    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, int_o, int_oe;
    logic [1:0]  bresp, rresp;
    logic        osc_tick = 1'b0, osc_running = 1'b1, alarm_match = 1'b0;
    logic        power_fail = 1'b0, osc_fail = 1'b0, on_backup = 1'b0;
    logic        hl_cfg = 1'b1, pin, irq_seen;
    int          errors = 0, samples_checked = 0;
    logic [7:0]  ra[6] = '{8'h18, 8'h18, 8'h1C, 8'h1C, 8'h1C, 8'h04};
    logic [7:0]  rw[6] = '{8'hEC, 8'h08, 8'hC5, 8'h05, 8'h00, 8'hFF};
    logic [7:0]  rx[6] = '{8'hEC, 8'h08, 8'h40, 8'h05, 8'h00, 8'h00};
    logic [1:0]  rr[6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3};
    logic [7:0]  d;

    always #4 ref_clk = ~ref_clk;

    rwi_rtc_irq #(.PULSE_CYCLES(PULSE), .WDT_DIV(4)) u_rwi_rtc_irq (
        .ref_clk(ref_clk), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .osc_tick(osc_tick),
        .osc_running(osc_running), .alarm_match(alarm_match), .power_fail(power_fail),
        .osc_fail(osc_fail), .on_backup(on_backup), .int_o(int_o), .int_oe(int_oe)
    );

    rwi_host_model u_rwi_host_model (
        .ref_clk(ref_clk), .arst_n(arst_n), .int_o(int_o), .int_oe(int_oe),
        .active_high(hl_cfg), .pin(pin), .irq_seen(irq_seen)
    );

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 100);
        chk({31'h0, bvalid}, 32'h1, "write answer");
        chk({30'h0, bresp}, {30'h0, er}, "write response");
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [7:0] v);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 100);
        v = rdata[7:0];
        chk({31'h0, rvalid}, 32'h1, "read answer");
        chk({30'h0, rresp}, {30'h0, er}, "read response");
        chk({8'h0, rdata[31:8]}, 32'h0, "upper read bits");
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string m);
        rd(a, (a == A_FLG || a == A_INT || a == A_WDG) ? 2'h0 : 2'h3, d);
        chk({24'h0, d}, {24'h0, e}, m);
    endtask

    task automatic osc(input int k);
        repeat (k) begin
            osc_tick <= 1'b1;
            @(posedge ref_clk);
            osc_tick <= 1'b0;
            @(posedge ref_clk);
        end
    endtask

    task automatic ev(input logic alarm);
        if (alarm) alarm_match <= 1'b1;
        else power_fail <= 1'b1;
        @(posedge ref_clk);
        alarm_match <= 1'b0;
        power_fail <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic irq(input logic e, input string m);
        chk({31'h0, irq_seen}, {31'h0, e}, m);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        conclude();
    end

    // ==========================================================
    // Tests
    initial begin
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (20) @(posedge ref_clk);
        rchk(A_FLG, 8'h00, "flags reset");
        rchk(A_INT, 8'h08, "intr reset");
        rchk(A_WDG, 8'h00, "wdog reset");
        for (int i = 0; i < 6; i++) begin
            wr(ra[i], rw[i], rr[i]);
            rchk(ra[i], rx[i], "readback");
        end
        $display("test registers done");

        wr(A_INT, 8'h88, 2'h0);
        wr(A_WDG, 8'h82, 2'h0);
        osc(7);
        irq(1'b0, "early timeout");
        osc(1);
        repeat (4) @(posedge ref_clk);
        irq(1'b1, "timeout pin");
        rchk(A_FLG, 8'h80, "timeout flag");
        repeat (2) @(posedge ref_clk);
        irq(1'b0, "level released");
        osc(5);
        wr(A_WDG, 8'hC0, 2'h0);
        osc(6);
        rchk(A_FLG, 8'h00, "strobe prevents");
        wr(A_WDG, 8'h00, 2'h0);
        osc(16);
        rchk(A_FLG, 8'h00, "zero disables");
        osc_running <= 1'b0;
        wr(A_WDG, 8'h01, 2'h0);
        osc(16);
        rchk(A_FLG, 8'h00, "stopped oscillator");
        osc_running <= 1'b1;
        osc(4);
        rchk(A_FLG, 8'h80, "oscillator restart");
        wr(A_WDG, 8'h00, 2'h0);
        $display("test watchdog done");

        for (int i = 0; i < 4; i++) begin
            wr(A_INT, 8'h08 | (i[0] ? (i[1] ? 8'h40 : 8'h20) : 8'h00), 2'h0);
            ev(i[1]);
            irq(i[0], "source enable");
            rchk(A_FLG, i[1] ? 8'h40 : 8'h20, "source flag");
        end
        wr(A_INT, 8'h28, 2'h0);
        ev(1'b1);
        irq(1'b0, "other source enabled");
        rchk(A_FLG, 8'h40, "alarm flag only");
        $display("test sources done");

        hl_cfg <= 1'b0;
        wr(A_INT, 8'h40, 2'h0);
        @(posedge ref_clk);
        chk({31'h0, pin}, 32'h1, "open drain idle");
        ev(1'b1);
        chk({30'h0, int_o, int_oe}, 32'h1, "open drain low");
        rchk(A_FLG, 8'h40, "active low flag");
        hl_cfg <= 1'b1;
        wr(A_INT, 8'h4C, 2'h0);
        ev(1'b1);
        irq(1'b1, "pulse start");
        repeat (15) @(posedge ref_clk);
        irq(1'b1, "pulse holds");
        repeat (7) @(posedge ref_clk);
        irq(1'b0, "pulse ends");
        rchk(A_FLG, 8'h40, "flag outlives pulse");
        ev(1'b1);
        irq(1'b1, "second pulse");
        rchk(A_FLG, 8'h40, "abort read");
        repeat (2) @(posedge ref_clk);
        irq(1'b0, "pulse cut short");
        $display("test pin modes done");

        wr(A_INT, 8'h48, 2'h0);
        on_backup <= 1'b1;
        ev(1'b1);
        irq(1'b0, "no irq on backup");
        rd(A_FLG, 2'h2, d);
        chk({24'h0, d}, 32'h0, "backup read data");
        wr(A_INT, 8'h00, 2'h2);
        on_backup <= 1'b0;
        repeat (3) @(posedge ref_clk);
        irq(1'b1, "irq after backup");
        rchk(A_FLG, 8'h40, "flag kept on backup");
        osc_fail <= 1'b1;
        @(posedge ref_clk);
        osc_fail <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rchk(A_FLG, 8'h10, "oscillator flag");
        rchk(A_FLG, 8'h10, "oscillator flag kept");
        wr(A_FLG, 8'h02, 2'h0);
        wr(A_FLG, 8'h00, 2'h0);
        rchk(A_FLG, 8'h00, "oscillator flag cleared");
        $display("test backup done");
        conclude();
    end
endmodule
`default_nettype wire
